// File: verilog/adcif_pkg.sv
// Constants, types and helpers shared by the converter interface.
// Assumes a 200 MHz system clock and a separate master conversion clock.
package adcif_pkg;

   // ************************************************
   // Widths
   // ************************************************
   localparam int RESULT_W = 14;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int HI_W = RESULT_W - BYTE_W;
   localparam int LEAD_W = WORD_W - RESULT_W;
   localparam int SHARED_W = 4;
   localparam int LO_PINS_W = RESULT_W - SHARED_W;

   // ************************************************
   // Counts and times
   // ************************************************
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CONV_EDGES = 5'h13;
   localparam logic [CNT_W-1:0] CONV_EDGES_LATE = 5'h14;
   localparam logic [CNT_W-1:0] SER_BITS = 5'h10;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam int MEAS_W = 8;
   localparam logic [MEAS_W-1:0] MEAS_ONE = 8'h01;
   localparam logic [MEAS_W-1:0] MEAS_MAX = 8'hff;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int START_WIN_NS = 30;
   // Least time, rounded up to whole system clocks
   localparam int START_WIN_CYC = (START_WIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [MEAS_W-1:0] WIN_CYC = MEAS_W'(START_WIN_CYC);

   // ************************************************
   // Types
   // ************************************************
   // Three levels of the format pin: high, zero volt, negative
   typedef enum logic [1:0] {FMT_WORD, FMT_SER_GATED, FMT_SER_CONT} adcif_fmt_t;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic start_n;
      logic hbsel;
   } adcif_host_t;

   // Open-drain pin: output level and enable, enable low while pulling
   typedef struct packed {
      logic o;
      logic oe_n;
   } adcif_od_t;

   // ************************************************
   // Read word selection
   // ************************************************
   function automatic logic [RESULT_W-1:0] adcif_rd_word(
      input logic [RESULT_W-1:0] res,
      input adcif_fmt_t fmt,
      input logic hbsel
   );
      logic [RESULT_W-1:0] w;
      w = res;
      if (fmt != FMT_WORD) begin
         if (hbsel) begin
            w = {{(RESULT_W-HI_W){1'b0}}, res[RESULT_W-1:BYTE_W]};
         end else begin
            w = {{HI_W{1'b0}}, res[BYTE_W-1:0]};
         end
      end
      return w;
   endfunction : adcif_rd_word

endpackage : adcif_pkg

// File: verilog/adcif_core.sv
// Host interface and conversion control of a 14-bit sampling converter.
// Assumes the analog core presents the held sample on sample_in and that
// open-drain pins have external pull-ups.
//
// Functional notes
// - Serial word: two zeros, result MSB first
// - Data changes on serial clock rise
// - Frame strobe low at conversion start
// - Serial pins only pull low or release
// - Serial clock derived from conversion clock
// - Low format levels enable serial pins
// - Negative level continuous, zero level gated
// - Serial-only part: clock-mode pin chooses behaviour
// - Mode 1 starts on start strobe rise
// - Mode 1 status pin is done interrupt
// - First read falling edge clears interrupt
// - Interrupt low after power-up, dummy read clears
// - Full-width read gives all bits, no serial except on serial-only part
// - Mode 1 first byte chosen by byte select
// - Mode 2 starts on select fall, byte select low
// - Mode 2 status pin is busy
// - Mode 2 full read waits then returns result
// - Serial sequence identical in both modes
// - Conversion takes 19 or 20 edges
// - Low byte, or upper six right-justified
// - High format level: full-width parallel; serial-only part still serial
`timescale 1ns/1ps
`default_nettype none

module adcif_core
   import adcif_pkg::*;
(
   // System clock and reset
   input wire logic clk,
   input wire logic reset,
   // Master conversion clock
   input wire logic link_clk,
   // Host bus controls
   input wire adcif_host_t host,
   // Configuration pins
   input wire adcif_fmt_t format_select,
   input wire logic serial_only,
   input wire logic clk_mode_cont,
   // Analog core
   input wire logic [RESULT_W-1:0] sample_in,
   output logic track_hold,
   // Parallel data bus
   output logic [RESULT_W-1:0] db_out,
   output logic db_oe_n,
   output logic db_hi_oe_n,
   // Shared status pin
   output logic status_n,
   // Open-drain serial pins
   output adcif_od_t serial_clock_out,
   output adcif_od_t serial_data_out,
   output adcif_od_t serial_frame_strobe_n
);

   // ************************************************
   // System domain: input synchronisers
   // ************************************************
   adcif_host_t h_s1_r, h_s2_r;
   adcif_fmt_t fmt_s1_r, fmt_s2_r;
   logic lck_s1_r, lck_s2_r, lck_d_r;
   logic done_s1_r, done_s2_r, done_d_r;
   logic done_tgl_r;
   logic [RESULT_W-1:0] result_lk_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         h_s1_r <= '1;
         h_s2_r <= '1;
         fmt_s1_r <= FMT_WORD;
         fmt_s2_r <= FMT_WORD;
         lck_s1_r <= 1'b0;
         lck_s2_r <= 1'b0;
         lck_d_r <= 1'b0;
         done_s1_r <= 1'b0;
         done_s2_r <= 1'b0;
         done_d_r <= 1'b0;
      end else begin
         h_s1_r <= host;
         h_s2_r <= h_s1_r;
         fmt_s1_r <= format_select;
         fmt_s2_r <= fmt_s1_r;
         lck_s1_r <= link_clk;
         lck_s2_r <= lck_s1_r;
         lck_d_r <= lck_s2_r;
         done_s1_r <= done_tgl_r;
         done_s2_r <= done_s1_r;
         done_d_r <= done_s2_r;
      end
   end

   // ************************************************
   // System domain: edge detection and start decode
   // ************************************************
   adcif_host_t h_d_r;
   logic busy_r, mode2_r, start_tgl_r, late_r;
   logic rd_act, rd_act_d, rd_fall, done_evt;
   logic start_m1, start_m2, start_req;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         h_d_r <= '1;
      end else begin
         h_d_r <= h_s2_r;
      end
   end

   assign rd_act = ~h_s2_r.cs_n & ~h_s2_r.rd_n;
   assign rd_act_d = ~h_d_r.cs_n & ~h_d_r.rd_n;
   assign rd_fall = rd_act & ~rd_act_d;
   assign done_evt = done_s2_r ^ done_d_r;
   assign start_m1 = h_s2_r.start_n & ~h_d_r.start_n & ~busy_r;
   // select fall, start tied low, byte select low
   assign start_m2 = ~h_s2_r.cs_n & h_d_r.cs_n & ~h_s2_r.start_n & ~h_s2_r.hbsel & ~busy_r;
   // A restart while busy is dropped, so a stray pulse cannot corrupt it
   assign start_req = start_m1 | start_m2;

   // ************************************************
   // System domain: conversion clock phase
   // ************************************************
   // Measures where the start falls in the conversion clock period so
   // the link side knows whether one more edge is owed.
   logic [MEAS_W-1:0] since_r, period_r;
   logic lck_rise, late_now;

   assign lck_rise = lck_s2_r & ~lck_d_r;
   assign late_now = (since_r <= period_r) && ((period_r - since_r) <= WIN_CYC);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         since_r <= '0;
         period_r <= MEAS_MAX;
      end else if (lck_rise) begin
         since_r <= MEAS_ONE;
         period_r <= since_r;
      end else if (since_r != MEAS_MAX) begin
         since_r <= since_r + MEAS_ONE;
      end
   end

   // ************************************************
   // System domain: conversion handshake and mode
   // ************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start_tgl_r <= 1'b0;
         late_r <= 1'b0;
         mode2_r <= 1'b0;
      end else if (start_req) begin
         start_tgl_r <= ~start_tgl_r;
         late_r <= late_now;
         mode2_r <= start_m2;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
      end else if (start_req) begin
         busy_r <= 1'b1;
      end else if (done_evt) begin
         busy_r <= 1'b0;
      end
   end

   // power up as if a conversion had finished
   logic irq_pend_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_pend_r <= 1'b1;
      end else if (done_evt && !mode2_r) begin
         // completion sets interrupt, wins over clear
         irq_pend_r <= 1'b1;
      end else if (rd_fall) begin
         irq_pend_r <= 1'b0;
      end
   end

   assign status_n = mode2_r ? ~busy_r : ~irq_pend_r;

   // ************************************************
   // System domain: result capture and parallel read
   // ************************************************
   logic [RESULT_W-1:0] result_r, db_r;
   logic db_oe_n_r, db_hi_oe_n_r;

   // Link result is held stable once its toggle is seen here
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         result_r <= '0;
      end else if (done_evt) begin
         result_r <= result_lk_r;
      end
   end

   // a read issued while busy waits for the result
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         db_r <= '0;
         db_oe_n_r <= 1'b1;
         db_hi_oe_n_r <= 1'b1;
      end else begin
         // full word, byte per byte select, byte layout
         db_r <= adcif_rd_word(result_r, fmt_s2_r, h_s2_r.hbsel);
         // The starting read must not drive stale data before busy rises
         db_oe_n_r <= ~(rd_act & ~busy_r & ~start_req);
         // upper pins drive only in full-width format
         db_hi_oe_n_r <= ~(rd_act & ~busy_r & ~start_req & (fmt_s2_r == FMT_WORD));
      end
   end

   assign db_out = db_r;
   assign db_oe_n = db_oe_n_r;
   assign db_hi_oe_n = db_hi_oe_n_r;

   // ************************************************
   // Link domain: synchronisers
   // ************************************************
   adcif_fmt_t fmt_l1_r, fmt_l2_r;
   logic so_l1_r, so_l2_r, cm_l1_r, cm_l2_r;
   logic st_l1_r, st_l2_r, st_d_r;

   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         fmt_l1_r <= FMT_WORD;
         fmt_l2_r <= FMT_WORD;
         so_l1_r <= 1'b0;
         so_l2_r <= 1'b0;
         cm_l1_r <= 1'b0;
         cm_l2_r <= 1'b0;
         st_l1_r <= 1'b0;
         st_l2_r <= 1'b0;
         st_d_r <= 1'b0;
      end else begin
         fmt_l1_r <= format_select;
         fmt_l2_r <= fmt_l1_r;
         so_l1_r <= serial_only;
         so_l2_r <= so_l1_r;
         cm_l1_r <= clk_mode_cont;
         cm_l2_r <= cm_l1_r;
         st_l1_r <= start_tgl_r;
         st_l2_r <= st_l1_r;
         st_d_r <= st_l2_r;
      end
   end

   // ************************************************
   // Link domain: conversion sequencer
   // ************************************************
   typedef enum logic {LK_IDLE, LK_CONV} adcif_lk_t;
   adcif_lk_t lk_state_r;
   logic [CNT_W-1:0] edge_cnt_r, edge_lim_r;
   logic [RESULT_W-1:0] sample_r;
   logic start_evt, serial_on, clk_cont;

   assign start_evt = st_l2_r ^ st_d_r;
   // low format levels, serial-only part always serial
   assign serial_on = so_l2_r | (fmt_l2_r != FMT_WORD);
   // format level sets clock, clock-mode pin overrides on the serial-only part
   assign clk_cont = so_l2_r ? cm_l2_r : (fmt_l2_r == FMT_SER_CONT);

   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         lk_state_r <= LK_IDLE;
         edge_cnt_r <= '0;
         edge_lim_r <= CONV_EDGES;
         sample_r <= '0;
         result_lk_r <= '0;
         done_tgl_r <= 1'b0;
      end else begin
         unique case (lk_state_r)
            LK_IDLE: begin
               if (start_evt) begin
                  lk_state_r <= LK_CONV;
                  edge_cnt_r <= CNT_ONE;
                  // 20 edges for a late start
                  edge_lim_r <= late_r ? CONV_EDGES_LATE : CONV_EDGES;
                  sample_r <= sample_in;
               end
            end
            LK_CONV: begin
               edge_cnt_r <= edge_cnt_r + CNT_ONE;
               if (edge_cnt_r == edge_lim_r) begin
                  lk_state_r <= LK_IDLE;
                  result_lk_r <= sample_r;
                  done_tgl_r <= ~done_tgl_r;
               end
            end
         endcase
      end
   end

   assign track_hold = (lk_state_r == LK_CONV);

   // ************************************************
   // Link domain: serial shifter
   // ************************************************
   // driven from the conversion start alone, whatever the mode
   logic [WORD_W-1:0] shift_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic frame_r, sclk_en;

   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         shift_r <= '0;
         bit_cnt_r <= '0;
         frame_r <= 1'b0;
      end else if (lk_state_r == LK_IDLE && start_evt) begin
         // leading zeros then result, frame opens at start
         shift_r <= {{LEAD_W{1'b0}}, sample_in};
         bit_cnt_r <= CNT_ONE;
         frame_r <= serial_on;
      end else if (frame_r) begin
         if (bit_cnt_r == SER_BITS) begin
            frame_r <= 1'b0;
         end else begin
            // next bit on each rising edge
            shift_r <= {shift_r[WORD_W-2:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + CNT_ONE;
         end
      end
   end

   // serial clock follows the conversion clock phase
   // The pin is pulled during the low phase only; enables change on the
   // rising edge while the clock is high, so no runt low pulse appears.
   assign sclk_en = serial_on & (clk_cont | frame_r);

   // pins only pull low or release
   assign serial_clock_out.o = 1'b0;
   assign serial_clock_out.oe_n = ~sclk_en | link_clk;
   assign serial_data_out.o = 1'b0;
   assign serial_data_out.oe_n = ~(frame_r & ~shift_r[WORD_W-1]);
   assign serial_frame_strobe_n.o = 1'b0;
   assign serial_frame_strobe_n.oe_n = ~frame_r;

endmodule : adcif_core

`default_nettype wire

// File: sim/adcif_core_assertions.sv
// Port checker for adcif_core, bound from the bench.
// Assumes format and variant pins change only while reset is high.
`timescale 1ns/1ps
`default_nettype none
module adcif_core_assertions
   import adcif_pkg::*;
(
   // Clocks and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic link_clk,
   // Inputs
   input wire adcif_host_t host,
   input wire adcif_fmt_t format_select,
   input wire logic serial_only,
   input wire logic clk_mode_cont,
   // Outputs
   input wire logic track_hold,
   input wire logic [RESULT_W-1:0] db_out,
   input wire logic db_oe_n,
   input wire logic db_hi_oe_n,
   input wire logic status_n,
   input wire adcif_od_t serial_clock_out,
   input wire adcif_od_t serial_data_out,
   input wire adcif_od_t serial_frame_strobe_n
);
   logic ser_on;
   logic gated;
   logic fmt_byte;
   assign ser_on = serial_only || format_select != FMT_WORD;
   assign gated = serial_only ? !clk_mode_cont : format_select == FMT_SER_GATED;
   assign fmt_byte = !serial_only && format_select != FMT_WORD;
   sequence frame_open;
      $fell(serial_frame_strobe_n.oe_n);
   endsequence
   sequence read_edge;
      !host.cs_n && !host.rd_n && $past(host.cs_n || host.rd_n);
   endsequence
   a_lead_zeros:
   assert property (@(posedge link_clk) disable iff (reset)
      frame_open |-> !serial_data_out.oe_n ##1 !serial_data_out.oe_n) else $error("lead");
   a_frame_len:
   assert property (@(posedge link_clk) disable iff (reset)
      frame_open |-> ##15 !serial_frame_strobe_n.oe_n ##1 serial_frame_strobe_n.oe_n)
      else $error("frame");
   a_conv_time:
   assert property (@(posedge link_clk) disable iff (reset) $rose(track_hold) |->
      track_hold[*8] ##1 track_hold[*8] ##1 track_hold[*3] ##[1:2] !track_hold)
      else $error("conv time");
   a_start_hold:
   assert property (@(posedge clk) disable iff (reset)
      $rose(host.start_n) && status_n && !track_hold |-> ##[1:160] track_hold) else $error("start");
   a_irq_clear:
   assert property (@(posedge clk) disable iff (reset)
      read_edge ##0 (host.start_n && !status_n) |-> ##[1:5] status_n) else $error("irq");
   a_busy_low:
   assert property (@(posedge clk) disable iff (reset) $fell(host.cs_n) && !host.start_n
      && !host.hbsel && status_n && !serial_only |-> ##[1:8] !status_n) else $error("busy");
   a_hi_byte:
   assert property (@(posedge clk) disable iff (reset) (fmt_byte && !host.cs_n && host.hbsel)[*4]
      ##0 !db_oe_n |-> db_out[13:6] == 8'h00) else $error("hi byte");
   a_lo_byte:
   assert property (@(posedge clk) disable iff (reset) (fmt_byte && !host.cs_n && !host.hbsel)[*4]
      ##0 !db_oe_n |-> db_out[13:8] == 6'h00) else $error("lo byte");
   a_hi_pins_off:
   assert property (@(posedge clk) disable iff (reset) fmt_byte |-> db_hi_oe_n) else $error("hi pins");
   a_no_serial:
   assert property (@(posedge clk) disable iff (reset) (!ser_on)[*4] |-> serial_clock_out.oe_n
      && serial_data_out.oe_n && serial_frame_strobe_n.oe_n) else $error("serial on");
   a_pull_only:
   assert property (@(posedge clk) disable iff (reset) !serial_data_out.oe_n |->
      !serial_data_out.o && (serial_clock_out.oe_n || !serial_clock_out.o)) else $error("drive");
   a_cont_clk:
   assert property (@(posedge clk) disable iff (reset)
      (ser_on && !gated)[*8] |-> ##[0:100] !serial_clock_out.oe_n) else $error("clk stop");
   a_gated_idle:
   assert property (@(posedge link_clk) disable iff (reset)
      (ser_on && gated && serial_frame_strobe_n.oe_n)[*3] |-> serial_clock_out.oe_n)
      else $error("clk idle");
endmodule : adcif_core_assertions
`default_nettype wire

// File: sim/adcif_rx_model.sv
// Serial receiver standing on the three open-drain lines.
// Assumes external pull-ups, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module adcif_rx_model
   import adcif_pkg::*;
(
   // Open-drain pins
   input wire adcif_od_t sclk_pin,
   input wire adcif_od_t data_pin,
   input wire adcif_od_t frame_pin,
   // Last word and frame count
   output logic [WORD_W-1:0] rx_word,
   output var int rx_frames
);
   logic sck;
   logic sd;
   logic fs_n;
   logic [WORD_W-1:0] sh;
   assign sck = sclk_pin.oe_n ? 1'b1 : sclk_pin.o;
   assign sd = data_pin.oe_n ? 1'b1 : data_pin.o;
   assign fs_n = frame_pin.oe_n ? 1'b1 : frame_pin.o;
   initial begin
      rx_frames = 0;
      sh = '0;
   end
   // sample on falling clock inside the frame
   always @(negedge sck) begin
      if (!fs_n) sh = {sh[WORD_W-2:0], sd};
   end
   // word complete when the frame closes
   always @(posedge fs_n) begin
      rx_word = sh;
      rx_frames = rx_frames + 1;
   end
endmodule : adcif_rx_model
`default_nettype wire

// File: sim/adcif_core_tb.sv
// Self-checking bench for adcif_core with a serial receiver model.
// Assumes package, design, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adcif_core_tb
   import adcif_pkg::*;
;
   logic clk, link_clk, reset, so, cm, th, db_oe_n, db_hi_oe_n, status_n;
   adcif_host_t host;
   adcif_fmt_t fmt;
   logic [RESULT_W-1:0] smp, db_out;
   adcif_od_t sck, sda, sfs;
   logic [WORD_W-1:0] rx_word;
   logic hi_seen;
   int rx_frames, n_errors, n_tests;

   adcif_core dut (.clk(clk), .reset(reset), .link_clk(link_clk), .host(host),
      .format_select(fmt), .serial_only(so), .clk_mode_cont(cm), .sample_in(smp),
      .track_hold(th), .db_out(db_out), .db_oe_n(db_oe_n), .db_hi_oe_n(db_hi_oe_n),
      .status_n(status_n), .serial_clock_out(sck), .serial_data_out(sda),
      .serial_frame_strobe_n(sfs));
   adcif_rx_model rx (.sclk_pin(sck), .data_pin(sda), .frame_pin(sfs), .rx_word(rx_word),
      .rx_frames(rx_frames));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   // Link clock phase kept unrelated to the system clock
   initial begin
      link_clk = 1'b0;
      #37;
      forever #62.5 link_clk = ~link_clk;
   end

   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk_val

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %b got %b", nm, e, g);
      end
   endtask : chk_bit

   function automatic logic [RESULT_W-1:0] exp_rd(logic [RESULT_W-1:0] r, logic byt, logic hb);
      if (!byt) return r;
      return hb ? {8'h00, r[13:8]} : {6'h00, r[7:0]};
   endfunction : exp_rd

   // Bounded wait: 0 data enable, 1 status, 2 track/hold
   task automatic wait_lvl(input int k, input logic v);
      int i;
      i = 0;
      while ((k == 0 ? db_oe_n : k == 1 ? status_n : th) !== v && i < 4000) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk_bit("wait", v, k == 0 ? db_oe_n : k == 1 ? status_n : th);
   endtask : wait_lvl

   task automatic rd(input logic hb, output logic [RESULT_W-1:0] d);
      @(posedge clk);
      host.cs_n <= 1'b0;
      host.rd_n <= 1'b0;
      host.hbsel <= hb;
      wait_lvl(0, 1'b0);
      d = db_out;
      hi_seen = db_hi_oe_n;
      @(posedge clk);
      host.cs_n <= 1'b1;
      host.rd_n <= 1'b1;
      wait_lvl(0, 1'b1);
   endtask : rd

   task automatic do_reset(input adcif_fmt_t f, input logic s, input logic c);
      logic [RESULT_W-1:0] d;
      @(posedge clk);
      reset <= 1'b1;
      fmt <= f;
      so <= s;
      cm <= c;
      host <= adcif_host_t'(4'he);
      // Held over five link cycles so both domains see it
      repeat (5) @(posedge link_clk);
      @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      if (!s) begin
         chk_bit("irq", 1'b0, status_n);
         rd(1'b0, d);
         chk_bit("irq", 1'b1, status_n);
      end
   endtask : do_reset

   task automatic conv(input logic m2);
      logic [RESULT_W-1:0] r;
      logic [RESULT_W-1:0] d;
      logic hb;
      logic byt;
      int f;
      r = RESULT_W'($urandom);
      hb = m2 ? 1'b0 : 1'($urandom);
      byt = !so && fmt != FMT_WORD;
      f = rx_frames;
      @(posedge clk);
      smp <= r;
      host.start_n <= 1'b0;
      if (!m2) begin
         repeat (3) @(posedge clk);
         host.start_n <= 1'b1;
         if (so) begin
            wait_lvl(2, 1'b1);
            wait_lvl(2, 1'b0);
         end else wait_lvl(1, 1'b0);
      end
      if (!so) begin
         rd(hb, d);
         chk_val("data", 16'(exp_rd(r, byt, hb)), 16'(d));
         chk_bit("hi_oe", byt, hi_seen);
         chk_bit("status", 1'b1, status_n);
         if (byt) begin
            rd(!hb, d);
            chk_val("data", 16'(exp_rd(r, byt, !hb)), 16'(d));
         end
      end
      chk_val("frames", 16'(so || byt ? f + 1 : f), 16'(rx_frames));
      if (so || byt) chk_val("serial", {2'b00, r}, rx_word);
   endtask : conv

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   initial begin
      #300000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      host = adcif_host_t'(4'he);
      fmt = FMT_WORD;
      so = 1'b0;
      cm = 1'b0;
      smp = '0;
      n_errors = 0;
      n_tests = 0;
      void'($urandom(32'h9960));
      // Three format levels, then the serial-only variant in both clock modes
      for (int k = 0; k < 5; k++) begin
         do_reset(adcif_fmt_t'(k < 3 ? k : 0), k > 2, k == 4);
         conv(1'b0);
         conv(1'b0);
         if (k < 3) conv(1'b1);
      end
      report_and_stop();
   end
endmodule : adcif_core_tb

bind adcif_core adcif_core_assertions chk (.clk, .reset, .link_clk, .host, .format_select,
   .serial_only, .clk_mode_cont, .track_hold, .db_out, .db_oe_n, .db_hi_oe_n, .status_n,
   .serial_clock_out, .serial_data_out, .serial_frame_strobe_n);
`default_nettype wire
